// ===== lnt_node.sv
`timescale 1ns/1ps
`include "lnt_params.svh"

module lnt_node
    import lnt_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic running,
    input wire logic role_wr,
    input wire logic role_master,
    input wire logic brk_wr,
    input wire logic [5:0] brk_len,
    input wire logic [31:0] baud_rate,
    input wire logic [15:0] bit_cycles,
    input wire logic dly_wr,
    input wire logic [31:0] dly_us,
    input wire logic gap_wr,
    input wire logic [31:0] gap_us,
    input wire logic sched_req,
    input wire lnt_hdr_t hdr_in,
    input wire lnt_hdr_t rx_hdr,
    input wire logic rx_diag_req,
    input wire lnt_byte_t tx_byte,
    output logic tx_ready,
    output logic lin_tx,
    output logic is_master,
    output logic sched_active,
    output logic [5:0] break_length_setting,
    output logic invalid_value_error,
    output logic busy
);

    typedef struct packed {
        lnt_state_t fsm;
        logic master;
        logic sched;
        logic [5:0] brk;
        logic [31:0] dly;
        logic [31:0] gap;
        logic err;
        logic tx;
        logic rdy;
        logic [15:0] bitc;
        logic [5:0] bits;
        logic [9:0] shreg;
        logic [5:0] pend_id;
        logic pend_hdr;
        logic diag_seen;
        logic diag_last;
        logic [1:0] hdr_step;
        logic tload;
        logic [31:0] tval;
        logic busy;
    } lnt_st_t;

    lnt_st_t st_reg;
    lnt_st_t st_next;
    logic tdone;

    // largest break allowed at this baud rate, shared by the write check
    function automatic logic [5:0] brk_limit(input logic [31:0] baud);
        if (baud <= `LNT_LOW_BAUD) begin
            brk_limit = `LNT_BRK_MAX_SLOW;
        end else if (baud < `LNT_SLOW_BAUD) begin
            brk_limit = `LNT_BRK_MAX_MID;
        end else begin
            brk_limit = `LNT_BRK_MAX;
        end
    endfunction

    function automatic logic [31:0] us_to_cyc(input logic [31:0] us);
        us_to_cyc = 32'(us * `LNT_US_CYCLES);
    endfunction

    // protected identifier byte
    function automatic logic [7:0] pid(input logic [5:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        pid = {p1, p0, id};
    endfunction

    // ---------------------------------------------------------------
    // spacing timer
    // ---------------------------------------------------------------
    lnt_timer u_timer (
        .clock(clock),
        .reset_n(reset_n),
        .load(st_reg.tload),
        .count_in(st_reg.tval),
        .done(tdone)
    );

    // ---------------------------------------------------------------
    // configuration and framing
    // ---------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.tload = 1'b0;
        st_next.err = 1'b0;
        // one setting copy for every session on this interface
        if (role_wr && !running) begin
            st_next.master = role_master;
            if (!role_master) begin
                st_next.sched = 1'b0;
            end
        end
        if (sched_req && !running) begin
            st_next.master = 1'b1;
            st_next.sched = 1'b1;
        end else if (sched_req && st_reg.master) begin
            st_next.sched = 1'b1;
        end
        // out-of-range writes keep the old value
        if (brk_wr && brk_len >= `LNT_BRK_MIN && brk_len <= brk_limit(baud_rate)) begin
            st_next.brk = brk_len;
        end
        if (dly_wr) begin
            if (st_reg.master) begin
                st_next.err = 1'b1;
            end else begin
                st_next.dly = us_to_cyc(dly_us);
            end
        end
        if (gap_wr) begin
            st_next.gap = us_to_cyc(gap_us);
        end
        // slave: remember header and diag request ends
        if (!st_reg.master && rx_hdr.valid) begin
            st_next.pend_hdr = 1'b1;
            st_next.pend_id = rx_hdr.id;
        end
        if (!st_reg.master && rx_diag_req) begin
            st_next.diag_seen = 1'b1;
            st_next.tload = 1'b1;
            st_next.tval = st_reg.dly;
        end
        st_next.rdy = 1'b0;
        case (st_reg.fsm)
            LNT_IDLE: begin
                st_next.tx = 1'b1;
                if (st_reg.master && st_reg.sched && hdr_in.valid && running) begin
                    st_next.fsm = LNT_BREAK;
                    st_next.tx = 1'b0;
                    st_next.bits = st_reg.brk;
                    st_next.bitc = bit_cycles;
                    st_next.pend_id = hdr_in.id;
                    st_next.hdr_step = 2'h0;
                end else if (tx_byte.valid && running && tdone &&
                             (st_reg.master || st_reg.pend_hdr) && !st_reg.diag_seen) begin
                    st_next.fsm = LNT_SHIFT;
                    st_next.rdy = 1'b1;
                    st_next.shreg = {1'b1, tx_byte.data, 1'b0};
                    st_next.bits = 6'(`LNT_FRAME_BITS);
                    st_next.bitc = bit_cycles;
                    st_next.diag_last = tx_byte.diag;
                    st_next.hdr_step = 2'h3;
                    // a header landing in this cycle survives the clear
                    if (tx_byte.last && !rx_hdr.valid) begin
                        st_next.pend_hdr = 1'b0;
                    end
                end else if (st_reg.diag_seen && tdone && !st_reg.tload && !rx_diag_req) begin
                    // only once the loaded delay has run out; a new request wins
                    st_next.diag_seen = 1'b0;
                end
            end
            LNT_BREAK: begin
                // dominant for exactly brk bit-times
                if (st_reg.bitc > 16'h0001) begin
                    st_next.bitc = st_reg.bitc - 16'h0001;
                end else if (st_reg.bits > 6'h01) begin
                    st_next.bitc = bit_cycles;
                    st_next.bits = st_reg.bits - 6'h01;
                end else begin
                    st_next.fsm = LNT_DELIM;
                    st_next.tx = 1'b1;
                    st_next.bitc = bit_cycles;
                    st_next.bits = 6'(`LNT_DELIM_BITS);
                end
            end
            LNT_DELIM: begin
                if (st_reg.bitc > 16'h0001) begin
                    st_next.bitc = st_reg.bitc - 16'h0001;
                end else begin
                    st_next.fsm = LNT_SHIFT;
                    st_next.shreg = {1'b1, `LNT_SYNC_BYTE, 1'b0};
                    st_next.bits = 6'(`LNT_FRAME_BITS);
                    st_next.bitc = bit_cycles;
                    st_next.hdr_step = 2'h1;
                    st_next.diag_last = 1'b0;
                end
            end
            LNT_SHIFT: begin
                st_next.tx = st_reg.shreg[0];
                if (st_reg.bitc > 16'h0001) begin
                    st_next.bitc = st_reg.bitc - 16'h0001;
                end else if (st_reg.bits > 6'h01) begin
                    st_next.bitc = bit_cycles;
                    st_next.bits = st_reg.bits - 6'h01;
                    st_next.shreg = {1'b1, st_reg.shreg[9:1]};
                end else if (st_reg.hdr_step == 2'h1) begin
                    st_next.shreg = {1'b1, pid(st_reg.pend_id), 1'b0};
                    st_next.bits = 6'(`LNT_FRAME_BITS);
                    st_next.bitc = bit_cycles;
                    st_next.hdr_step = 2'h2;
                end else begin
                    st_next.fsm = LNT_GAP;
                    st_next.tx = 1'b1;
                    // diag frames keep their spacing in both roles
                    if (st_reg.diag_last) begin
                        st_next.tload = 1'b1;
                        st_next.tval = st_reg.gap;
                    end
                end
            end
            LNT_GAP: begin
                st_next.fsm = LNT_WAIT;
            end
            LNT_WAIT: begin
                // timer load lands one cycle after the gap state
                st_next.fsm = LNT_IDLE;
            end
            default: begin
                st_next.fsm = LNT_IDLE;
            end
        endcase
        // busy is kept in a flop so the output has no decode behind it
        st_next.busy = (st_next.fsm != LNT_IDLE);
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_reg <= '0;
            st_reg.fsm <= LNT_IDLE;
            st_reg.master <= 1'b0;
            st_reg.brk <= `LNT_BRK_DEF;
            st_reg.dly <= 32'(`LNT_RSP_DELAY_US_DEF * `LNT_US_CYCLES);
            st_reg.gap <= 32'(`LNT_GAP_US_DEF * `LNT_US_CYCLES);
            st_reg.tx <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all from state flip-flops
    // ---------------------------------------------------------------
    assign lin_tx = st_reg.tx;
    assign tx_ready = st_reg.rdy;
    assign is_master = st_reg.master;
    assign sched_active = st_reg.sched;
    assign break_length_setting = st_reg.brk;
    assign invalid_value_error = st_reg.err;
    assign busy = st_reg.busy;

endmodule

// ===== lnt_params.svh
`ifndef LNT_PARAMS_SVH
`define LNT_PARAMS_SVH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define LNT_CLK_HZ 200000000
`define LNT_RSP_DELAY_US_DEF 50000
`define LNT_GAP_US_DEF 0
`define LNT_US_CYCLES 200

// ---------------------------------------------------------------
// break length limits, bit-times
// ---------------------------------------------------------------
`define LNT_BRK_MIN 6'h0A
`define LNT_BRK_MAX 6'h24
`define LNT_BRK_MAX_SLOW 6'h0E
// cap between the two slow points, a design choice that keeps bus hold time
`define LNT_BRK_MAX_MID 6'h14
`define LNT_BRK_DEF 6'h0D
`define LNT_SLOW_BAUD 32'h00002580
`define LNT_LOW_BAUD 32'h00000960

// ---------------------------------------------------------------
// bit layout of a byte frame on the wire
// ---------------------------------------------------------------
`define LNT_DELIM_BITS 8'h01
`define LNT_SYNC_BYTE 8'h55
`define LNT_FRAME_BITS 4'hA

`endif

// ===== lnt_pkg.sv
package lnt_pkg;

    // transmit byte stream from the user
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
        logic diag;
    } lnt_byte_t;

    // schedule header request
    typedef struct packed {
        logic valid;
        logic [5:0] id;
    } lnt_hdr_t;

    typedef enum logic [5:0] {
        LNT_IDLE = 6'b000001,
        LNT_BREAK = 6'b000010,
        LNT_DELIM = 6'b000100,
        LNT_SHIFT = 6'b001000,
        LNT_WAIT = 6'b010000,
        LNT_GAP = 6'b100000
    } lnt_state_t;

endpackage

// ===== lnt_timer.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// down counter for minimum time spacing
// ---------------------------------------------------------------
module lnt_timer
    import lnt_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [31:0] count_in,
    output logic done
);

    typedef struct packed {
        logic [31:0] cnt;
    } lnt_tmr_t;

    lnt_tmr_t st_reg;
    lnt_tmr_t st_next;

    // count reaches zero and stays there
    always_comb begin
        st_next = st_reg;
        if (load) begin
            st_next.cnt = count_in;
        end else if (st_reg.cnt != 32'h00000000) begin
            st_next.cnt = st_reg.cnt - 32'h00000001;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign done = (st_reg.cnt == 32'h00000000);

endmodule

// ===== lnt_node_props.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checker for the node
// ---------------------------------------------------------------
module lnt_node_props
    import lnt_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic running,
    input wire logic brk_wr,
    input wire logic [5:0] brk_len,
    input wire logic [31:0] baud_rate,
    input wire logic [15:0] bit_cycles,
    input wire logic dly_wr,
    input wire logic sched_req,
    input wire logic lin_tx,
    input wire logic is_master,
    input wire logic sched_active,
    input wire logic [5:0] break_length_setting,
    input wire logic invalid_value_error
);
    logic [21:0] low_reg;
    logic [21:0] low_next;
    logic [5:0] lim;
    // length of the current dominant run on the line
    always_comb begin
        low_next = lin_tx ? 22'h0 : low_reg + 22'h1;
    end
    always_ff @(posedge clock) begin
        low_reg <= reset_n ? low_next : 22'h0;
    end
    // slow links cap the break so the bus hold time is kept
    assign lim = baud_rate <= 32'h960 ? 6'h0E : baud_rate < 32'h2580 ? 6'h14 : 6'h24;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_brk_range: assert property (break_length_setting >= 6'h0A && break_length_setting <= 6'h24)
        else $error("break length out of range");
    a_brk_take: assert property (brk_wr && brk_len >= 6'h0A && brk_len <= lim
        |=> break_length_setting == $past(brk_len)) else $error("legal break not taken");
    a_brk_refuse: assert property (brk_wr && (brk_len < 6'h0A || brk_len > lim)
        |=> $stable(break_length_setting)) else $error("illegal break taken");
    a_brk_cause: assert property ($changed(break_length_setting) |-> $past(brk_wr))
        else $error("break changed without write");
    a_err_master: assert property (dly_wr && is_master |=> invalid_value_error)
        else $error("no error on master delay write");
    a_err_cause: assert property (invalid_value_error |-> $past(dly_wr) && $past(is_master))
        else $error("spurious error");
    a_role_held: assert property ($changed(is_master) |-> !$past(running))
        else $error("role changed while running");
    a_sched_force: assert property (sched_req && !running |=> is_master && sched_active)
        else $error("schedule did not force master");
    a_sched_cause: assert property ($rose(sched_active) |-> $past(sched_req))
        else $error("schedule active without request");
    a_break_run: assert property ($rose(lin_tx) && is_master |-> low_reg <= 22'(bit_cycles) * 9
        || low_reg == 22'(break_length_setting) * 22'(bit_cycles)) else $error("bad break");
    a_slave_run: assert property ($rose(lin_tx) && !is_master |-> low_reg <= 22'(bit_cycles) * 9)
        else $error("slave sent a break");
endmodule

bind lnt_node lnt_node_props props_i (.*);

// ===== lnt_bus_peer.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// remote node: headers and diag requests on demand
// ---------------------------------------------------------------
module lnt_bus_peer
    import lnt_pkg::*;
(
    input wire logic clock,
    input wire logic lin_tx,
    input wire logic clr,
    input wire logic hdr_go,
    input wire logic [5:0] hdr_id,
    input wire logic diag_go,
    output lnt_hdr_t rx_hdr,
    output logic rx_diag_req,
    output logic [21:0] low_max
);
    logic [21:0] run;
    initial begin
        {rx_hdr, rx_diag_req, run, low_max} = '0;
    end
    // id is scrambled outside a header so stale values never match
    always @(posedge clock) begin
        rx_hdr <= {hdr_go, hdr_go ? hdr_id : ~hdr_id};
        rx_diag_req <= diag_go;
        run <= lin_tx ? 22'h0 : run + 22'h1;
        if (clr) low_max <= 22'h0;
        else if (run > low_max) low_max <= run;
    end
endmodule

// ===== lnt_node_tb.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// self-checking bench for the node
// ---------------------------------------------------------------
module lnt_node_tb;
    import lnt_pkg::*;
    logic clock, reset_n, running, role_wr, role_master, brk_wr, dly_wr, gap_wr;
    logic sched_req, rx_diag_req, tx_ready, lin_tx, is_master, sched_active;
    logic invalid_value_error, busy, hdr_go, diag_go, clr, seen;
    logic [5:0] brk_len, exp_brk, hdr_id, break_length_setting;
    logic [31:0] baud_rate, dly_us, gap_us;
    integer seed;
    logic [15:0] bit_cycles;
    logic [21:0] low_max;
    lnt_hdr_t hdr_in, rx_hdr;
    lnt_byte_t tx_byte;
    int errors, check_count, cyc, n;
    logic [31:0] bauds [4] = '{32'h960, 32'h12C0, 32'h2580, 32'h4B00};
    logic [5:0] edges [6] = '{6'h09, 6'h0A, 6'h0E, 6'h0F, 6'h24, 6'h25};
    lnt_node uut (.*);
    lnt_bus_peer peer (.*);
    // clock and hang guard
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc > 20000) begin
            errors++;
            test_done();
        end
    end
    task automatic tick(int k = 1);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    // a refused length leaves the old one in place
    function automatic logic [5:0] brk_exp(logic [5:0] cur, logic [5:0] len, logic [31:0] b);
        logic [5:0] lim;
        lim = b <= 32'h960 ? 6'h0E : b < 32'h2580 ? 6'h14 : 6'h24;
        return (len >= 6'h0A && len <= lim) ? len : cur;
    endfunction
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
        seen = invalid_value_error;
        tick();
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        tick();
        while (busy !== 1'b0 && k < 3000) begin
            tick();
            k++;
        end
    endtask
    // waits for the next byte taken, k counts the cycles spent
    task automatic wait_rdy(output int k);
        k = 0;
        tick();
        while (tx_ready !== 1'b1 && k < 2000) begin
            tick();
            k++;
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // main sequence
    initial begin
        seed = 32'h8902;
        {reset_n, running, role_wr, role_master, brk_wr, dly_wr, gap_wr} = 7'h00;
        {sched_req, hdr_go, diag_go, clr} = 4'h0;
        {hdr_in, tx_byte, brk_len, hdr_id} = '0;
        {baud_rate, bit_cycles, dly_us, gap_us} = {32'h4B00, 16'h4, 32'h1, 32'h1};
        tick(3);
        reset_n = 1'b1;
        tick();
        chk("role", 0, is_master);
        chk("sched", 0, sched_active);
        chk("brk", 13, break_length_setting);
        gap_wr = 1'b1;
        pulse(dly_wr);
        chk("err", 0, seen | invalid_value_error);
        exp_brk = 6'h0D;
        for (n = 0; n < 40; n++) begin
            baud_rate = bauds[$random(seed) & 3];
            brk_len = n < 6 ? edges[n] : 6'($random(seed));
            pulse(brk_wr);
            exp_brk = brk_exp(exp_brk, brk_len, baud_rate);
            chk("brk", exp_brk, break_length_setting);
        end
        baud_rate = 32'h4B00;
        brk_len = 6'h24;
        pulse(brk_wr);
        running = 1'b1;
        pulse(diag_go);
        tx_byte = {1'b1, 8'hA5, 1'b1, 1'b1};
        tick(20);
        pulse(hdr_go);
        n = 22;
        while (!tx_ready && n < 2000) begin
            tick();
            n++;
        end
        tx_byte = '0;
        chk("rsp late", 1, n >= 200 && n < 2000);
        wait_idle();
        chk("slave run", 1, low_max <= 22'h24);
        role_master = 1'b1;
        pulse(role_wr);
        chk("role run", 0, is_master);
        running = 1'b0;
        pulse(role_wr);
        chk("role", 1, is_master);
        chk("sched", 0, sched_active);
        pulse(dly_wr);
        chk("err", 1, seen | invalid_value_error);
        role_master = 1'b0;
        pulse(role_wr);
        chk("role", 0, is_master);
        pulse(sched_req);
        chk("sched", 1, is_master & sched_active);
        pulse(clr);
        running = 1'b1;
        hdr_in = {1'b1, 6'h15};
        n = 0;
        while (lin_tx && n < 500) begin
            tick();
            n++;
        end
        hdr_in = '0;
        wait_idle();
        chk("break", 22'h90, low_max);
        // two diag request bytes as master: frame plus gap between takes
        tx_byte = {1'b1, 8'h3C, 1'b0, 1'b1};
        wait_rdy(n);
        wait_rdy(n);
        tx_byte = '0;
        chk("req gap", 1, n >= 10 * 4 + 200 && n < 2000);
        test_done();
    end
endmodule
